//--- rtl/ubdr_defines.vh
// How it works
// - Reception flag sets when line reads 0 at first sample slot of start search.
// - Reception flag is read-only; its setting sets interrupt status bit 0, which raises the interrupt when masked in.
// - Reception flag clears on a rejected false start or on an idle character.
// - Data buffer reads give received bits; writes load transmit bits.
// - Reset leaves the data buffer contents alone; no reset value.
// - One rate-select register sets the rate for receiver and transmitter.
// - Prescale field 00/01/10/11 divides by 1/3/4/13; read/write, reset clears.
// - Divisor field divides by two to the field value, 1 to 128; reset clears.
// - Bit rate is source clock over 64 times prescale times divisor.
// - Source clock is bus clock or crystal reference, chosen by an option bit.
`ifndef UBDR_DEFINES_VH
`define UBDR_DEFINES_VH
`define UBDR_ADR_STATUS2 4'h0
`define UBDR_ADR_DATA 4'h4
`define UBDR_ADR_RATE 4'h8
`define UBDR_ADR_OPTION 4'hC
`define UBDR_ADR_IRQ_STAT 5'h10
`define UBDR_ADR_IRQ_MASK 5'h14
`define UBDR_RATE_RESET 8'h00
`define UBDR_PD_00 4'h0
`define UBDR_PD_01 4'h2
`define UBDR_PD_10 4'h3
`define UBDR_PD_11 4'hC
`define UBDR_PRE_BITS 5:4
`define UBDR_DIV_BITS 2:0
`define UBDR_SRC_BIT 0
`define UBDR_RPF_BIT 0
`define UBDR_BASE_DIV 4'h3
`define UBDR_IRQ_START 0
`define UBDR_IRQ_FALSE 1
`define UBDR_IRQ_IDLE 2
`endif

//--- rtl/ubdr_top.v
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ubdr_defines.vh"
module ubdr_top
(
   input wire CLK, // Bus clock, 100 MHz
   input wire RST_N, // Asynchronous reset, active low
   input wire CRYSTAL_REF_EN, // One-cycle pulse per crystal reference clock edge
   input wire WB_CYC_I, // Wishbone cycle
   input wire WB_STB_I, // Wishbone strobe
   input wire WB_WE_I, // Wishbone write enable
   input wire [3:0] WB_SEL_I, // Wishbone byte selects
   input wire [7:0] WB_ADR_I, // Wishbone byte address
   input wire [31:0] WB_DAT_I, // Wishbone write data
   output reg [31:0] WB_DAT_O, // Wishbone read data
   output reg WB_ACK_O, // Wishbone acknowledge
   input wire RXD, // Receive line
   input wire RX_ENABLE, // Receiver enabled
   input wire RX_FALSE_START, // Receiver rejected false start, pulse
   input wire RX_IDLE_CHAR, // Receiver found idle character, pulse
   input wire RX_LOAD, // Receive shifter delivers a byte, pulse
   input wire [7:0] RX_BYTE, // Byte from receive shifter
   output reg [7:0] TX_BYTE, // Byte for transmit shifter
   output reg TX_LOAD, // Transmit byte written, pulse
   output reg RATE_16X, // Sample tick at 16x bit rate, pulse
   output reg [3:0] SAMPLE_SLOT, // Slot number within bit period
   output reg RECEPTION_ACTIVE, // Reception in progress flag
   output wire IRQ // Interrupt, level, active high
);
   reg [7:0] received_bits;
   reg [2:0] rate_divisor_field;
   reg [1:0] rate_prescale_field;
   reg rate_clock_source_select;
   reg [2:0] irq_stat;
   reg [2:0] irq_mask;
   reg [3:0] base_cnt;
   reg [3:0] pre_cnt;
   reg [7:0] div_cnt;
   reg [3:0] prescale_divisor;
   reg [7:0] rate_divisor;
   reg searching;
   reg start_evt;
   wire src_tick;
   wire base_tick;
   wire pre_tick;
   wire access;
   wire wr;
   wire rd;
   wire [2:0] clr_bits;
   wire [2:0] set_bits;

   assign access = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // Writes land at the edge where the master sees ack high
   assign wr = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
   assign rd = access & ~WB_WE_I;
   assign src_tick = rate_clock_source_select ? CRYSTAL_REF_EN : 1'b1;

   always @*
   begin
      case (rate_prescale_field)
         2'b00: prescale_divisor = `UBDR_PD_00;
         2'b01: prescale_divisor = `UBDR_PD_01;
         2'b10: prescale_divisor = `UBDR_PD_10;
         default: prescale_divisor = `UBDR_PD_11;
      endcase
      rate_divisor = (8'h01 << rate_divisor_field) - 8'h01;
   end

   // Divide by 4 then prescale gives 16x; divisor then slows it; 16 slots make 64
   assign base_tick = src_tick & (base_cnt == `UBDR_BASE_DIV);
   assign pre_tick = base_tick & (pre_cnt == prescale_divisor);

   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         base_cnt <= 4'h0;
         pre_cnt <= 4'h0;
         div_cnt <= 8'h00;
         RATE_16X <= 1'b0;
      end
      else
      begin
         RATE_16X <= 1'b0;
         if (src_tick)
            base_cnt <= base_tick ? 4'h0 : base_cnt + 4'h1;
         if (base_tick)
            pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
         if (pre_tick)
         begin
            if (div_cnt >= rate_divisor)
            begin
               div_cnt <= 8'h00;
               RATE_16X <= 1'b1;
            end
            else
               div_cnt <= div_cnt + 8'h01;
         end
      end
   end

   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         SAMPLE_SLOT <= 4'h1;
         searching <= 1'b1;
         RECEPTION_ACTIVE <= 1'b0;
         start_evt <= 1'b0;
      end
      else
      begin
         start_evt <= 1'b0;
         if (RX_FALSE_START | RX_IDLE_CHAR | ~RX_ENABLE)
         begin
            RECEPTION_ACTIVE <= 1'b0;
            searching <= 1'b1;
            SAMPLE_SLOT <= 4'h1;
         end
         else if (RATE_16X)
         begin
            SAMPLE_SLOT <= (SAMPLE_SLOT == 4'hF) ? 4'h0 : SAMPLE_SLOT + 4'h1;
            if (searching)
            begin
               SAMPLE_SLOT <= 4'h1;
               if (!RXD)
               begin
                  RECEPTION_ACTIVE <= 1'b1;
                  searching <= 1'b0;
                  start_evt <= 1'b1;
                  SAMPLE_SLOT <= 4'h2;
               end
            end
         end
      end
   end

   assign set_bits = {RX_IDLE_CHAR, RX_FALSE_START, start_evt};
   assign clr_bits = (wr && WB_ADR_I[4:0] == `UBDR_ADR_IRQ_STAT) ? WB_DAT_I[2:0] : 3'h0;
   assign IRQ = |(irq_stat & irq_mask);

   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rate_prescale_field <= 2'b00;
         rate_divisor_field <= 3'b000;
         rate_clock_source_select <= 1'b0;
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
         TX_LOAD <= 1'b0;
      end
      else
      begin
         WB_ACK_O <= access;
         TX_LOAD <= 1'b0;
         irq_stat <= (irq_stat & ~clr_bits) | set_bits;
         if (wr)
         begin
            case (WB_ADR_I[4:0])
               {1'b0, `UBDR_ADR_DATA}: TX_LOAD <= 1'b1;
               {1'b0, `UBDR_ADR_RATE}:
               begin
                  rate_prescale_field <= WB_DAT_I[`UBDR_PRE_BITS];
                  rate_divisor_field <= WB_DAT_I[`UBDR_DIV_BITS];
               end
               {1'b0, `UBDR_ADR_OPTION}: rate_clock_source_select <= WB_DAT_I[`UBDR_SRC_BIT];
               `UBDR_ADR_IRQ_MASK: irq_mask <= WB_DAT_I[2:0];
               default: ;
            endcase
         end
         if (rd)
         begin
            case (WB_ADR_I[4:0])
               {1'b0, `UBDR_ADR_STATUS2}: WB_DAT_O <= {31'h0, RECEPTION_ACTIVE};
               {1'b0, `UBDR_ADR_DATA}: WB_DAT_O <= {24'h0, received_bits};
               {1'b0, `UBDR_ADR_RATE}:
                  WB_DAT_O <= {26'h0, rate_prescale_field, 1'b0, rate_divisor_field};
               {1'b0, `UBDR_ADR_OPTION}: WB_DAT_O <= {31'h0, rate_clock_source_select};
               `UBDR_ADR_IRQ_STAT: WB_DAT_O <= {29'h0, irq_stat};
               `UBDR_ADR_IRQ_MASK: WB_DAT_O <= {29'h0, irq_mask};
               default: WB_DAT_O <= 32'h00000000;
            endcase
         end
      end
   end

   // Data buffer halves carry no reset
   always @(posedge CLK)
   begin
      if (RX_LOAD)
         received_bits <= RX_BYTE;
      if (wr && WB_ADR_I[4:0] == {1'b0, `UBDR_ADR_DATA})
         TX_BYTE <= WB_DAT_I[7:0];
   end
endmodule // ubdr_top
`default_nettype wire

//--- dv/ubdr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ubdr_properties (
   input wire logic CLK, // clk
   input wire logic RST_N, // rst
   input wire logic WB_CYC_I, // bus
   input wire logic WB_STB_I, // bus
   input wire logic WB_ACK_O, // bus
   input wire logic RXD, // line
   input wire logic RX_ENABLE, // rx on
   input wire logic RX_FALSE_START, // rx
   input wire logic RX_IDLE_CHAR, // rx
   input wire logic TX_LOAD, // tx
   input wire logic RATE_16X, // tick
   input wire logic RECEPTION_ACTIVE // flag
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_ack_follows: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack late");
   a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
   a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack unasked");
   a_flag_sets: assert property (!RECEPTION_ACTIVE && RATE_16X && !RXD && RX_ENABLE
      && !RX_FALSE_START && !RX_IDLE_CHAR |=> RECEPTION_ACTIVE)
      else $error("flag not set");
   a_flag_waits: assert property (!RECEPTION_ACTIVE && !RATE_16X |=> !RECEPTION_ACTIVE)
      else $error("flag set off slot");
   a_flag_clears: assert property (RX_FALSE_START || RX_IDLE_CHAR || !RX_ENABLE
      |=> !RECEPTION_ACTIVE)
      else $error("flag not cleared");
   a_tick_spacing: assert property (RATE_16X |=> !RATE_16X [*3])
      else $error("tick too soon");
   a_load_single: assert property (TX_LOAD |=> !TX_LOAD) else $error("load long");
endmodule // ubdr_properties
bind ubdr_top ubdr_properties i_ubdr_properties (.*);
`default_nettype wire

//--- dv/ubdr_remote.sv
`timescale 1ns/10ps
`default_nettype none
module ubdr_remote (
   input wire logic clk, // clock
   input wire logic start_bit, // hold line low
   input wire logic [1:0] event_req, // 1 false start, 2 idle
   output logic rxd, // line, idles high
   output logic false_start, // pulse
   output logic idle_char // pulse
);
   always @(posedge clk)
   begin
      rxd <= !start_bit;
      false_start <= event_req == 2'h1;
      idle_char <= event_req == 2'h2;
   end
endmodule // ubdr_remote
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic CLK = 0, RST_N = 0, cyc = 0, stb = 0, we = 0, sb = 0, ld = 0, en = 1;
   wire logic txl;
   wire logic [3:0] slot;
   logic [1:0] ev = 0, xc = 0;
   logic [7:0] adr = 0, rxb = 0;
   logic [31:0] dat = 0, q;
   wire logic rxd, fs, idl, ack, tick, flag, irq;
   wire logic [7:0] txb;
   wire logic [31:0] dout;
   int fail_count = 0, num_checks = 0, n;
   logic [7:0] rate [8] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h04, 8'h15, 8'h26, 8'h37};
   int per [8] = '{4, 24, 64, 416, 64, 384, 1024, 6656};
   ubdr_top i_ubdr_top (.CLK(CLK), .RST_N(RST_N), .CRYSTAL_REF_EN(xc == 2'h3), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_ADR_I(adr), .WB_DAT_I(dat),
      .WB_DAT_O(dout), .WB_ACK_O(ack), .RXD(rxd), .RX_ENABLE(en), .RX_FALSE_START(fs),
      .RX_IDLE_CHAR(idl), .RX_LOAD(ld), .RX_BYTE(rxb), .TX_BYTE(txb), .TX_LOAD(txl),
      .RATE_16X(tick), .SAMPLE_SLOT(slot), .RECEPTION_ACTIVE(flag), .IRQ(irq));
   ubdr_remote i_ubdr_remote (.clk(CLK), .start_bit(sb), .event_req(ev), .rxd(rxd),
      .false_start(fs), .idle_char(idl));
   always #5 CLK = ~CLK;
   always @(posedge CLK) xc <= xc + 2'h1;
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge CLK); while (ack !== 1'b1);
      q = dout;
      cyc <= 0;
      stb <= 0;
   endtask
   // Skips two ticks that may straddle a rate change before measuring
   task period;
      repeat (2) do @(posedge CLK); while (tick !== 1'b1);
      n = 0;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (tick !== 1'b1);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge CLK);
      RST_N <= 1;
      bus(0, 8'h08, 0); `CHK("rate reset", 32'h0, q)
      for (int i = 0; i < 8; i++)
      begin
         bus(1, 8'h08, {24'h0, rate[i]});
         bus(0, 8'h08, 0); `CHK("rate", {24'h0, rate[i]}, q)
         period; `CHK("period", per[i], n)
      end
      $display("rate table done");
      bus(1, 8'h08, 0);
      bus(1, 8'h0C, 1);
      period; `CHK("crystal period", 16, n)
      bus(1, 8'h0C, 0);
      ld <= 1;
      rxb <= 8'hA5;
      @(posedge CLK);
      ld <= 0;
      rxb <= 8'h5A;
      // Data buffer is only written or read whole, never modified in place
      bus(1, 8'h04, 32'h3C);
      #1 `CHK("tx load", 1'b1, txl)
      bus(0, 8'h04, 0); `CHK("rx byte", 32'hA5, q)
      `CHK("tx byte", 8'h3C, txb)
      RST_N <= 0;
      @(posedge CLK);
      RST_N <= 1;
      bus(0, 8'h04, 0); `CHK("rx kept", 32'hA5, q)
      `CHK("tx kept", 8'h3C, txb)
      $display("data buffer done");
      // Third pass switches the receiver off instead of sending an event
      for (int k = 1; k < 4; k++)
      begin
         @(posedge CLK);
         sb <= 1;
         repeat (9) @(posedge CLK);
         sb <= 0;
         bus(1, 8'h00, 0);
         bus(0, 8'h00, 0); `CHK("flag set", 32'h1, q)
         #1 `CHK("flag irq", 1'b0, irq)
         @(posedge CLK);
         ev <= k[1:0];
         en <= k != 3;
         @(posedge CLK);
         ev <= 0;
         en <= 1;
         repeat (2) @(posedge CLK);
         #1 `CHK("flag clear", 1'b0, flag)
         `CHK("slot", 4'h1, slot)
      end
      bus(1, 8'h14, 32'h7);
      #1 `CHK("irq set", 1'b1, irq)
      bus(1, 8'h10, 32'h7);
      #1 `CHK("irq clear", 1'b0, irq)
      bus(0, 8'h18, 0); `CHK("unmapped", 32'h0, q)
      $display("flag and irq done");
      complete_run;
   end
   initial
   begin
      #600us;
      fail_count++;
      complete_run;
   end
endmodule // tb_top
`default_nettype wire
